// >>> verilog/npp_parser.sv
// Functional notes
// - First octet is the version; anything but zero drops the message.
// - Fields are taken most significant octet first; spare bits ignored.
// - Any bad relay header field discards the whole message.
// - Only message identifiers 20 to 28 are accepted; others discard.
// - Message length past the frame end drops the rest of the message.
// - Unknown data block identifier skips only that block.
// - Block length past frame end drops rest; earlier blocks stand.
// - Other bad field in a data block drops only that block.
// - Other bad field in the message part discards the whole message.
// - Relay header is id 0, source, relay station, destination octets.
// - Source address valid only for 1, 2 or 4 to 95.
// - Relay station address valid only for 0 (unknown) or 4 to 95.
// - Destination address valid only for 1, 2, 4 to 95 or 127.
// - Established station named as relay re-sends to the destination.
// - Relaying station passes responses back to the relayed joiner.
// - Every block is identifier, length, then n fields; n+2 octets.
// - Terminating block is the single octet 255.
// - Everything after the terminating block is ignored.
`timescale 1ns/100ps
`default_nettype none
`include "npp_defs.svh"

module npp_parser (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire npp_pkg::npp_oct_s oct_in,
    input  wire logic [7:0]        own_addr,
    input  wire logic              established,
    output wire npp_pkg::npp_dat_s dat_out,
    output wire npp_pkg::npp_rep_s blk_out,
    output wire npp_pkg::npp_rep_s msg_out,
    output wire npp_pkg::npp_rly_s rly_out
);
    import npp_pkg::*;

    // -------------------------------------------------------------------
    // State and input decode.
    // -------------------------------------------------------------------
    npp_ctx_s ctx_r;
    npp_ctx_s ctx_nxt;
    npp_dat_s dat_r;
    npp_dat_s dat_nxt;
    npp_rep_s blk_r;
    npp_rep_s blk_nxt;
    npp_rep_s msg_r;
    npp_rep_s msg_nxt;
    npp_rly_s rly_r;
    npp_rly_s rly_nxt;

    // Octet strobe, octet data and the decodes used by the walker.
    wire logic       take;
    wire logic [7:0] d;
    wire logic       mid_ok;
    wire logic       bid_ok;
    wire logic       short_len;
    wire logic       last_body;
    wire logic [7:0] len_body;
    wire logic [7:0] hdr_dst;
    wire logic       hdr_ok;
    wire logic       relay_hit;
    wire logic       relay_back;
    assign take      = oct_in.valid;
    assign d         = oct_in.data;
    assign mid_ok    = npp_in_rng(d, `NPP_MID_MIN, `NPP_MID_MAX);
    assign bid_ok    = npp_in_rng(ctx_r.bid, `NPP_BID_MIN,
                                  `NPP_BID_MAX);
    assign short_len = d < `NPP_BLK_HDR;
    assign len_body  = d - `NPP_BLK_HDR;
    assign last_body = ctx_r.cnt == `NPP_ONE;
    assign hdr_dst   = (ctx_r.st == NPP_S_HDR) ? d : ctx_r.dst;

    // Relay header check and relay decision.
    npp_fwd_chk u_fwd (
        .src         (ctx_r.src),
        .fwd         (ctx_r.fwd),
        .dst         (hdr_dst),
        .own_addr    (own_addr),
        .established (established),
        .joiner_v    (ctx_r.jv),
        .joiner_addr (ctx_r.ja),
        .hdr_ok      (hdr_ok),
        .relay_hit   (relay_hit),
        .relay_back  (relay_back)
    );

    // -------------------------------------------------------------------
    // Octet walker.
    // -------------------------------------------------------------------
    // One octet is consumed per strobe; verdicts leave as one-cycle pulses.
    always_comb begin
        ctx_nxt = ctx_r;
        dat_nxt = '0;
        blk_nxt = '0;
        msg_nxt = '0;
        rly_nxt = '0;
        if (take) begin
            if (oct_in.sof) begin
                ctx_nxt.hdr_seen = 1'b0;
                if (d == `NPP_VER) begin
                    ctx_nxt.st = NPP_S_MID;
                end else begin
                    ctx_nxt.st = NPP_S_DROP;
                    msg_nxt = '{1'b1, NPP_RES_DROP, `NPP_ZERO8};
                end
            end else begin
                unique case (ctx_r.st)
                    NPP_S_IDLE, NPP_S_DONE, NPP_S_DROP: begin
                        ctx_nxt.st = ctx_r.st;
                    end
                    NPP_S_MID: begin
                        if (d == `NPP_FWD_ID && !ctx_r.hdr_seen) begin
                            ctx_nxt.st       = NPP_S_HDR;
                            ctx_nxt.hidx     = `NPP_HIDX_SRC;
                            ctx_nxt.hdr_seen = 1'b1;
                        end else if (mid_ok) begin
                            ctx_nxt.mid = d;
                            ctx_nxt.st  = NPP_S_MLEN;
                        end else begin
                            ctx_nxt.st = NPP_S_DROP;
                            msg_nxt = '{1'b1, NPP_RES_DROP, d};
                        end
                    end
                    NPP_S_HDR: begin
                        ctx_nxt.hidx = ctx_r.hidx + `NPP_HIDX_ONE;
                        if (ctx_r.hidx == `NPP_HIDX_SRC) begin
                            ctx_nxt.src = d;
                        end else if (ctx_r.hidx == `NPP_HIDX_FWD) begin
                            ctx_nxt.fwd = d;
                        end else begin
                            ctx_nxt.dst = d;
                            if (hdr_ok) begin
                                ctx_nxt.st = NPP_S_MID;
                            end else begin
                                ctx_nxt.st = NPP_S_DROP;
                                msg_nxt = '{1'b1, NPP_RES_DROP, `NPP_ZERO8};
                            end
                        end
                    end
                    NPP_S_MLEN: begin
                        if (short_len) begin
                            ctx_nxt.st = NPP_S_DROP;
                            msg_nxt = '{1'b1, NPP_RES_DROP, ctx_r.mid};
                        end else begin
                            ctx_nxt.cnt = len_body;
                            ctx_nxt.st  = (len_body == `NPP_ZERO8) ?
                                          NPP_S_BID : NPP_S_MBODY;
                        end
                    end
                    NPP_S_MBODY: begin
                        dat_nxt     = '{1'b1, ctx_r.mid, d};
                        ctx_nxt.cnt = ctx_r.cnt - `NPP_ONE;
                        if (last_body) begin
                            ctx_nxt.st = NPP_S_BID;
                        end
                    end
                    NPP_S_BID: begin
                        if (d == `NPP_TERM) begin
                            ctx_nxt.st = NPP_S_DONE;
                            msg_nxt = '{1'b1, NPP_RES_OK, ctx_r.mid};
                            if (ctx_r.hdr_seen && relay_hit) begin
                                rly_nxt    = '{1'b1, ctx_r.dst};
                                ctx_nxt.jv = 1'b1;
                                ctx_nxt.ja = ctx_r.src;
                            end else if (ctx_r.hdr_seen && relay_back) begin
                                rly_nxt = '{1'b1, ctx_r.ja};
                            end
                        end else begin
                            ctx_nxt.bid = d;
                            ctx_nxt.st  = NPP_S_BLEN;
                        end
                    end
                    NPP_S_BLEN: begin
                        if (short_len) begin
                            ctx_nxt.st = NPP_S_BID;
                            blk_nxt = '{1'b1, NPP_RES_SKIP, ctx_r.bid};
                        end else if (len_body == `NPP_ZERO8) begin
                            ctx_nxt.st = NPP_S_BID;
                            blk_nxt = '{1'b1, bid_ok ? NPP_RES_OK :
                                        NPP_RES_SKIP, ctx_r.bid};
                        end else begin
                            ctx_nxt.cnt = len_body;
                            ctx_nxt.st  = NPP_S_BBODY;
                        end
                    end
                    NPP_S_BBODY: begin
                        dat_nxt = '{bid_ok, ctx_r.bid, d};
                        ctx_nxt.cnt = ctx_r.cnt - `NPP_ONE;
                        if (last_body) begin
                            ctx_nxt.st = NPP_S_BID;
                            blk_nxt = '{1'b1, bid_ok ? NPP_RES_OK :
                                        NPP_RES_SKIP, ctx_r.bid};
                        end
                    end
                endcase
            end
            // Frame end: an unfinished message or block is truncated.
            if (oct_in.eof) begin
                if (ctx_nxt.st == NPP_S_BLEN ||
                    ctx_nxt.st == NPP_S_BBODY) begin
                    blk_nxt = '{1'b1, NPP_RES_TRUNC, ctx_nxt.bid};
                end
                if (ctx_nxt.st != NPP_S_DONE && ctx_nxt.st != NPP_S_DROP &&
                    ctx_nxt.st != NPP_S_IDLE) begin
                    msg_nxt = '{1'b1, NPP_RES_TRUNC, ctx_nxt.mid};
                end
                ctx_nxt.st = NPP_S_IDLE;
            end
        end
    end

    // -------------------------------------------------------------------
    // Registers.
    // -------------------------------------------------------------------
    // Context and all outputs are flip-flops cleared by reset.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctx_r <= '{NPP_S_IDLE, 8'h00, 2'h0, 1'b0, 8'h00, 8'h00,
                       8'h00, 8'h00, 8'h00, 1'b0, 8'h00};
            dat_r <= '0;
            blk_r <= '0;
            msg_r <= '0;
            rly_r <= '0;
        end else begin
            ctx_r <= ctx_nxt;
            dat_r <= dat_nxt;
            blk_r <= blk_nxt;
            msg_r <= msg_nxt;
            rly_r <= rly_nxt;
        end
    end

    assign dat_out = dat_r;
    assign blk_out = blk_r;
    assign msg_out = msg_r;
    assign rly_out = rly_r;

    // -------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    wire logic mid_oct;
    assign mid_oct = take && !oct_in.sof && !oct_in.eof;

    sequence s_msg_drop;
        msg_r.valid && msg_r.res == NPP_RES_DROP;
    endsequence
    sequence s_blk_open;
        ctx_r.st == NPP_S_BBODY && take && oct_in.eof && !last_body;
    endsequence

    chk_ver_drop: assert property (
        take && oct_in.sof && d != `NPP_VER |=> s_msg_drop
        ##1 !msg_r.valid) else $error("Bad version not dropped.");
    chk_hdr_drop: assert property (
        ctx_r.st == NPP_S_HDR && ctx_r.hidx == `NPP_HIDX_DST && mid_oct &&
        !hdr_ok |=> s_msg_drop and (ctx_r.st == NPP_S_DROP))
        else $error("Bad relay header not dropped.");
    chk_mid_range: assert property (
        ctx_r.st == NPP_S_MID && mid_oct && d != `NPP_FWD_ID &&
        !mid_ok |=> s_msg_drop) else $error("Bad message id accepted.");
    chk_mlen_trunc: assert property (
        ctx_r.st == NPP_S_MBODY && take && !oct_in.sof && oct_in.eof &&
        !last_body |=> msg_r.valid && msg_r.res == NPP_RES_TRUNC)
        else $error("Short message not truncated.");
    chk_unk_skip: assert property (
        blk_r.valid && !npp_in_rng(blk_r.id, `NPP_BID_MIN, `NPP_BID_MAX)
        |-> blk_r.res != NPP_RES_OK) else $error("Unknown block accepted.");
    chk_blk_trunc: assert property (
        (s_blk_open and !oct_in.sof) |=> blk_r.valid &&
        blk_r.res == NPP_RES_TRUNC && msg_r.res == NPP_RES_TRUNC)
        else $error("Overrun block not truncated.");
    chk_short_blk: assert property (
        ctx_r.st == NPP_S_BLEN && mid_oct && short_len |=> blk_r.valid &&
        blk_r.res == NPP_RES_SKIP && ctx_r.st == NPP_S_BID)
        else $error("Bad block length not skipped.");
    chk_term_done: assert property (
        ctx_r.st == NPP_S_BID && mid_oct && d == `NPP_TERM |=>
        msg_r.valid && msg_r.res == NPP_RES_OK && ctx_r.st == NPP_S_DONE)
        else $error("Terminator not honoured.");
    chk_done_quiet: assert property (
        ctx_r.st == NPP_S_DONE && !(take && oct_in.sof) |=>
        !dat_r.valid && !blk_r.valid && !msg_r.valid)
        else $error("Octets after terminator acted on.");
    chk_relay_ok: assert property (
        rly_r.valid |-> msg_r.valid && msg_r.res == NPP_RES_OK &&
        $past(ctx_r.hdr_seen)) else $error("Relay without good message.");

endmodule // npp_parser
`default_nettype wire

// >>> verilog/npp_defs.svh
`ifndef NPP_DEFS_SVH
`define NPP_DEFS_SVH

// -----------------------------------------------------------------------
// Message layout values.
// -----------------------------------------------------------------------
`define NPP_VER       8'h00
`define NPP_FWD_ID    8'h00
`define NPP_MID_MIN   8'h14
`define NPP_MID_MAX   8'h1C
`define NPP_BID_MIN   8'h01
`define NPP_BID_MAX   8'h0E
`define NPP_TERM      8'hFF
`define NPP_BLK_HDR   8'h02
`define NPP_ONE       8'h01
`define NPP_ZERO8     8'h00

// -----------------------------------------------------------------------
// Relay header address ranges and octet positions.
// -----------------------------------------------------------------------
`define NPP_ADDR_UNK  8'h00
`define NPP_ADDR_1    8'h01
`define NPP_ADDR_2    8'h02
`define NPP_ADDR_LO   8'h04
`define NPP_ADDR_HI   8'h5F
`define NPP_ADDR_ALL  8'h7F
`define NPP_HIDX_SRC  2'h0
`define NPP_HIDX_FWD  2'h1
`define NPP_HIDX_DST  2'h2
`define NPP_HIDX_ONE  2'h1

`endif

// >>> verilog/npp_pkg.sv
package npp_pkg;

    // -------------------------------------------------------------------
    // Parser states and result codes.
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        NPP_S_IDLE  = 4'h0,
        NPP_S_MID   = 4'h1,
        NPP_S_MLEN  = 4'h3,
        NPP_S_MBODY = 4'h2,
        NPP_S_BID   = 4'h6,
        NPP_S_BLEN  = 4'h7,
        NPP_S_BBODY = 4'h5,
        NPP_S_DONE  = 4'h4,
        NPP_S_HDR   = 4'h9,
        NPP_S_DROP  = 4'h8
    } npp_st_e;

    typedef enum logic [1:0] {
        NPP_RES_OK    = 2'h0,
        NPP_RES_SKIP  = 2'h1,
        NPP_RES_TRUNC = 2'h2,
        NPP_RES_DROP  = 2'h3
    } npp_res_e;

    // -------------------------------------------------------------------
    // Carriers.
    // -------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       sof;
        logic       eof;
        logic [7:0] data;
    } npp_oct_s;

    typedef struct packed {
        logic       valid;
        npp_res_e   res;
        logic [7:0] id;
    } npp_rep_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] id;
        logic [7:0] data;
    } npp_dat_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] dest;
    } npp_rly_s;

    typedef struct packed {
        npp_st_e    st;
        logic [7:0] cnt;
        logic [1:0] hidx;
        logic       hdr_seen;
        logic [7:0] src;
        logic [7:0] fwd;
        logic [7:0] dst;
        logic [7:0] mid;
        logic [7:0] bid;
        logic       jv;
        logic [7:0] ja;
    } npp_ctx_s;

    // True when v lies in lo..hi inclusive.
    function automatic logic npp_in_rng(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
        npp_in_rng = (v >= lo) && (v <= hi);
    endfunction

endpackage

// >>> verilog/npp_fwd_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "npp_defs.svh"

module npp_fwd_chk (
    input  wire logic [7:0] src,
    input  wire logic [7:0] fwd,
    input  wire logic [7:0] dst,
    input  wire logic [7:0] own_addr,
    input  wire logic       established,
    input  wire logic       joiner_v,
    input  wire logic [7:0] joiner_addr,
    output wire logic       hdr_ok,
    output wire logic       relay_hit,
    output wire logic       relay_back
);
    import npp_pkg::*;

    // -------------------------------------------------------------------
    // Address field checks.
    // -------------------------------------------------------------------
    // Station range shared by all three address octets.
    wire logic src_ok;
    wire logic fwd_ok;
    wire logic dst_ok;
    assign src_ok = (src == `NPP_ADDR_1) || (src == `NPP_ADDR_2) ||
                    npp_in_rng(src, `NPP_ADDR_LO, `NPP_ADDR_HI);
    assign fwd_ok = (fwd == `NPP_ADDR_UNK) ||
                    npp_in_rng(fwd, `NPP_ADDR_LO, `NPP_ADDR_HI);
    assign dst_ok = (dst == `NPP_ADDR_1) || (dst == `NPP_ADDR_2) ||
                    (dst == `NPP_ADDR_ALL) ||
                    npp_in_rng(dst, `NPP_ADDR_LO, `NPP_ADDR_HI);
    assign hdr_ok = src_ok && fwd_ok && dst_ok;

    // -------------------------------------------------------------------
    // Relay decisions.
    // -------------------------------------------------------------------
    // Unknown forwarder never matches, since a forwarder octet of zero is excluded.
    assign relay_hit  = established && (fwd == own_addr) &&
                        (fwd != `NPP_ADDR_UNK);
    // Answers headed for a joiner we relayed for go back to it.
    assign relay_back = established && joiner_v && !relay_hit &&
                        (dst == joiner_addr);

endmodule // npp_fwd_chk
`default_nettype wire

// >>> verification/npp_far_station.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------------
// Far station model: sends whole message frames octet by octet.
// ---------------------------------------------------------------------
module npp_far_station (
    input  wire logic             clk,
    output var npp_pkg::npp_oct_s oct
);
    import npp_pkg::*;

    // The line starts idle with no frame marks.
    initial begin
        oct = '0;
    end

    // Idle cycles show no stale octet, so the data is inverted each time.
    task automatic go_idle();
        oct.valid = 1'b0;
        oct.sof   = 1'b0;
        oct.eof   = 1'b0;
        oct.data  = ~oct.data;
    endtask

    // Sends one frame; gap idle cycles between octets model a slow sender.
    task automatic send_frame(input logic [7:0] b[$], input int gap);
        int i;
        for (i = 0; i < b.size(); i++) begin
            @(posedge clk);
            #1;
            oct.valid = 1'b1;
            oct.sof   = (i == 0);
            oct.eof   = (i == b.size() - 1);
            oct.data  = b[i];
            repeat (gap) begin
                @(posedge clk);
                #1;
                go_idle();
            end
        end
        @(posedge clk);
        #1;
        go_idle();
    endtask
endmodule // npp_far_station

`default_nettype wire

// >>> verification/net_param_message_parser_test.sv
`timescale 1ns/100ps
`default_nettype none

module net_param_message_parser_test;
    import npp_pkg::*;

    logic       clk;
    logic       nrst;
    logic [7:0] own_addr;
    logic       established;
    npp_oct_s   oct;
    npp_dat_s   dat;
    npp_rep_s   blk;
    npp_rep_s   msg;
    npp_rly_s   rly;
    int         bad_count = 0;
    int         checks = 0;
    logic [7:0] dat_q[$];
    logic [7:0] did_q[$];
    npp_rep_s   blk_q[$];
    npp_rep_s   msg_q[$];
    logic [7:0] rly_q[$];

    // ---------------------------------------------------------------
    // Clock, far station and parser.
    // ---------------------------------------------------------------
    // The clock runs at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    npp_far_station i_far (.clk(clk), .oct(oct));

    npp_parser i_dut (
        .clk(clk), .nrst(nrst), .oct_in(oct), .own_addr(own_addr),
        .established(established), .dat_out(dat), .blk_out(blk),
        .msg_out(msg), .rly_out(rly)
    );

    // Collects every output pulse for later judging.
    always @(posedge clk) begin
        if (dat.valid === 1'b1) begin
            dat_q.push_back(dat.data);
            did_q.push_back(dat.id);
        end
        if (blk.valid === 1'b1) blk_q.push_back(blk);
        if (msg.valid === 1'b1) msg_q.push_back(msg);
        if (rly.valid === 1'b1) rly_q.push_back(rly.dest);
    end

    // ---------------------------------------------------------------
    // Compare and helper tasks.
    // ---------------------------------------------------------------
    task automatic cmp_oct(input string w, input logic [7:0] e,
                           input logic [7:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic cmp_res(input string w, input npp_res_e e,
                           input npp_res_e g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %0d seen %0d", w, e, g);
        end
    endtask

    // Clears the capture, sends one frame and lets the pulses land.
    task automatic run(input logic [7:0] b[$], input int gap);
        dat_q.delete();
        did_q.delete();
        blk_q.delete();
        msg_q.delete();
        rly_q.delete();
        i_far.send_frame(b, gap);
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Judges the single message verdict and the count of block verdicts.
    task automatic chk_msg(input npp_res_e r, input logic [7:0] id,
                           input int nblk, input bit use_id);
        cmp_oct("msg count", 8'h01, 8'(msg_q.size()));
        cmp_res("msg res", r, msg_q[0].res);
        if (use_id) cmp_oct("msg id", id, msg_q[0].id);
        cmp_oct("blk count", 8'(nblk), 8'(blk_q.size()));
    endtask

    task automatic chk_blk(input int k, input npp_res_e r,
                           input logic [7:0] id);
        cmp_res("blk res", r, blk_q[k].res);
        cmp_oct("blk id", id, blk_q[k].id);
    endtask

    // ---------------------------------------------------------------
    // Scenarios.
    // ---------------------------------------------------------------
    // A plain message with one block, sent back to back and slowly.
    task automatic t_walk();
        int g;
        for (g = 0; g < 3; g += 2) begin
            run('{8'h00, 8'h14, 8'h04, 8'h12, 8'h34, 8'h02, 8'h03, 8'hBB,
                  8'hFF}, g);
            chk_msg(NPP_RES_OK, 8'h14, 1, 1'b1);
            chk_blk(0, NPP_RES_OK, 8'h02);
            cmp_oct("dat count", 8'h03, 8'(dat_q.size()));
            cmp_oct("dat 0", 8'h12, dat_q[0]);
            cmp_oct("dat 1", 8'h34, dat_q[1]);
            cmp_oct("dat 2", 8'hBB, dat_q[2]);
            cmp_oct("dat id 0", 8'h14, did_q[0]);
            cmp_oct("dat id 2", 8'h02, did_q[2]);
        end
        $display("walk done");
    endtask

    // Version check, then every message identifier around the legal span.
    task automatic t_ids();
        logic [7:0] id;
        bit         ok;
        run('{8'h01, 8'h14, 8'h02, 8'hFF}, 0);
        chk_msg(NPP_RES_DROP, 8'h00, 0, 1'b1);
        for (id = 8'h13; id <= 8'h1D; id++) begin
            ok = (id >= 8'h14) && (id <= 8'h1C);
            run('{8'h00, id, 8'h02, 8'hFF}, 0);
            chk_msg(ok ? NPP_RES_OK : NPP_RES_DROP, id, 0, ok);
        end
        $display("ids done");
    endtask

    // Relay header fields at and beyond the edges of their ranges.
    task automatic t_header();
        logic [23:0] tab [10] = '{24'h030001, 24'h600001, 24'h000001,
            24'h010101, 24'h016001, 24'h010003, 24'h010060, 24'h010080,
            24'h5F007F, 24'h020404};
        int k;
        for (k = 0; k < 10; k++) begin
            run('{8'h00, 8'h00, tab[k][23:16], tab[k][15:8], tab[k][7:0],
                  8'h14, 8'h02, 8'hFF}, 0);
            chk_msg(k >= 8 ? NPP_RES_OK : NPP_RES_DROP,
                    k >= 8 ? 8'h14 : 8'h00, 0, 1'b1);
        end
        $display("header done");
    endtask

    // Relay onward only when established, then relay back to the joiner.
    task automatic t_relay();
        run('{8'h00, 8'h00, 8'h04, 8'h05, 8'h7F, 8'h14, 8'h02, 8'hFF}, 0);
        cmp_oct("rly count", 8'h00, 8'(rly_q.size()));
        established = 1'b1;
        run('{8'h00, 8'h00, 8'h04, 8'h05, 8'h7F, 8'h14, 8'h02, 8'hFF}, 0);
        chk_msg(NPP_RES_OK, 8'h14, 0, 1'b1);
        cmp_oct("rly count", 8'h01, 8'(rly_q.size()));
        cmp_oct("rly dest", 8'h7F, rly_q[0]);
        run('{8'h00, 8'h00, 8'h01, 8'h09, 8'h04, 8'h15, 8'h02, 8'hFF}, 0);
        cmp_oct("rly count", 8'h01, 8'(rly_q.size()));
        cmp_oct("rly dest", 8'h04, rly_q[0]);
        established = 1'b0;
        $display("relay done");
    endtask

    // Unknown and short blocks skip alone; overruns and late octets.
    task automatic t_blocks();
        run('{8'h00, 8'h14, 8'h02, 8'h0F, 8'h03, 8'hDD, 8'h0E, 8'h03,
              8'hEE, 8'hFF}, 0);
        chk_msg(NPP_RES_OK, 8'h14, 2, 1'b1);
        chk_blk(0, NPP_RES_SKIP, 8'h0F);
        chk_blk(1, NPP_RES_OK, 8'h0E);
        cmp_oct("dat count", 8'h01, 8'(dat_q.size()));
        run('{8'h00, 8'h14, 8'h02, 8'h04, 8'h01, 8'h06, 8'h02, 8'hFF}, 0);
        chk_blk(0, NPP_RES_SKIP, 8'h04);
        chk_blk(1, NPP_RES_OK, 8'h06);
        run('{8'h00, 8'h14, 8'h06, 8'hAA}, 0);
        chk_msg(NPP_RES_TRUNC, 8'h14, 0, 1'b1);
        run('{8'h00, 8'h14, 8'h02, 8'h02, 8'h03, 8'hBB, 8'h03, 8'h0A,
              8'hCC}, 0);
        chk_msg(NPP_RES_TRUNC, 8'h14, 2, 1'b1);
        chk_blk(0, NPP_RES_OK, 8'h02);
        chk_blk(1, NPP_RES_TRUNC, 8'h03);
        run('{8'h00, 8'h14, 8'h01, 8'hFF}, 0);
        chk_msg(NPP_RES_DROP, 8'h00, 0, 1'b0);
        run('{8'h00, 8'h14, 8'h02, 8'hFF, 8'h02, 8'h03, 8'hBB, 8'hFF}, 0);
        chk_msg(NPP_RES_OK, 8'h14, 0, 1'b1);
        cmp_oct("dat count", 8'h00, 8'(dat_q.size()));
        $display("blocks done");
    endtask

    // ---------------------------------------------------------------
    // Verdict, watchdog and main sequence.
    // ---------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The tests need about 370 cycles; this allows over fifty times that.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("[ERR] run length expected finish seen timeout");
        test_done();
    end

    // Holds reset for four cycles, then runs every scenario.
    initial begin
        nrst        = 1'b0;
        own_addr    = 8'h05;
        established = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_walk();
        t_ids();
        t_header();
        t_relay();
        t_blocks();
        test_done();
    end
endmodule // net_param_message_parser_test

`default_nettype wire
